// ==== rtl/rpr_map.svh ====
// address map, field positions and frame constants of the remote parameter request framer
`ifndef RPR_MAP_SVH
`define RPR_MAP_SVH
// frame bytes
`define RPR_DELIM 8'h7e
`define RPR_TYPE_REQ 8'h17
`define RPR_TYPE_RSP 8'h97
`define RPR_CSUM_OK 8'hff
`define RPR_STATUS_OK 8'h00
// byte offsets within a request frame
`define RPR_OFF_TYPE 16'h0003
`define RPR_OFF_ID 16'h0004
`define RPR_OFF_ADDR 16'h0005
`define RPR_OFF_ADDR_END 16'h000c
`define RPR_OFF_OPTS 16'h000f
`define RPR_OFF_NAME_HI 16'h0010
`define RPR_OFF_NAME_LO 16'h0011
`define RPR_OFF_VAL 16'h0012
`define RPR_LEN_MIN 16'h000f
`define RPR_LEN_TO_LAST 16'h0002
// option bit positions
`define RPR_OPT_NOACK 0
`define RPR_OPT_APPLY 1
`define RPR_OPT_SECURE 4
// value store
`define RPR_VAL_MAX 4'h8
// response layout
`define RPR_RSP_LEN_SET 8'h05
`define RPR_RSP_LEN_QRY 8'h07
`define RPR_RSP_EXTRA 4'h4
`define RPR_RSP_LAST_SET 4'h8
`define RPR_RSP_LAST_QRY 4'ha
// apb register byte addresses
`define RPR_REG_CTRL 8'h00
`define RPR_REG_STATUS 8'h04
`define RPR_REG_QVAL 8'h08
`define RPR_REG_LAST 8'h0c
`define RPR_REG_DEST_HI 8'h10
`define RPR_REG_DEST_LO 8'h14
`define RPR_REG_VAL_HI 8'h18
`define RPR_REG_VAL_LO 8'h1c
`define RPR_REG_VAL_LEN 8'h20
// control bits
`define RPR_CTRL_EN 0
`define RPR_CTRL_APPLY 1
`define RPR_CTRL_RESET 32'h0000_0001
// fifo
`define RPR_FIFO_DEPTH 16
`endif

// ==== rtl/rpr_pkg.sv ====
// types shared by the remote parameter request framer
package rpr_pkg;
	// parser states
	typedef enum logic [2:0] {
		RPR_ST_IDLE = 3'b000,
		RPR_ST_LEN_HI = 3'b001,
		RPR_ST_LEN_LO = 3'b010,
		RPR_ST_BODY = 3'b011,
		RPR_ST_CSUM = 3'b100
	} rpr_state_t;
	// request handed to the radio side
	typedef struct packed {
		logic [63:0] dest;
		logic [15:0] name;
		logic [7:0] id;
		logic no_ack;
		logic apply_now;
		logic secure;
		logic is_query;
		logic [3:0] val_len;
	} rpr_req_t;
	// apb request from the master
	typedef struct packed {
		logic [7:0] paddr;
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] pwdata;
	} rpr_apb_req_t;
endpackage

// ==== rtl/rpr_fifo.sv ====
// byte fifo with registered full and empty flags
module rpr_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	// storage words
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic push;
	logic pop;
	logic [AW:0] next_count;

	// full and empty are registered from the next count, so both sides see honest flags
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;
	assign next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	assign out_data_o = mem[rd_ptr];

	// ===========================================
	// pointers and flags
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			in_ready_o <= 1'b1;
			out_valid_o <= 1'b0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
			count <= next_count;
			in_ready_o <= (next_count != (AW+1)'(DEPTH));
			out_valid_o <= (next_count != '0);
		end
	end

	// ===========================================
	// data words, no reset needed
	always_ff @(posedge sys_clk_i) begin
		if (push) begin
			mem[wr_ptr] <= in_data_i;
		end
	end
endmodule

// ==== rtl/rpr_framer.sv ====
// remote parameter request framer: serial frame parser, response builder and apb registers
//
// The register offsets and register access over APB are this design's own decisions.
`include "rpr_map.svh"

//Contract
//- request type 0x17, answer type 0x97
//- offset 0 holds start delimiter
//- 16-bit length counts bytes before checksum
//- frame id zero suppresses response
//- response carries request's frame id
//- option bit 0 sends without acknowledgement
//- option bit 1 applies change immediately
//- apply clear only queues change until apply
//- option bit 4 sends securely
//- option bits act independently in any mix
//- offset 16 carries two-character parameter name
//- bytes from offset 18 are new value
//- no value bytes means query, return value
//- checksum is 0xFF minus byte sum from 3
module rpr_framer (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// serial bytes from the host
	input wire logic rx_valid_i,
	input wire logic [7:0] rx_data_i,
	output logic rx_ready_o,
	// response bytes to the host
	output logic tx_valid_o,
	output logic [7:0] tx_data_o,
	input wire logic tx_ready_i,
	// request to the radio side
	output logic req_valid_o,
	output rpr_pkg::rpr_req_t req_o,
	output logic apply_cmd_o,
	// apb slave
	input wire rpr_pkg::rpr_apb_req_t apb_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o
);
	// ===========================================
	// declarations
	rpr_pkg::rpr_state_t state;
	logic [15:0] len; // body length from the frame
	logic [15:0] off; // offset of the byte being taken
	logic [7:0] sum; // running sum from the type byte
	logic [7:0] f_type;
	logic [7:0] f_id;
	logic [63:0] f_dest;
	logic [7:0] f_opts;
	logic [15:0] f_name;
	logic [3:0] f_vlen;
	logic f_long; // value overran the store
	logic [7:0] val [`RPR_VAL_MAX]; // value bytes of the last frame
	logic [7:0] v_mem [`RPR_VAL_MAX]; // value bytes of the accepted request
	logic [31:0] ctrl;
	logic [15:0] qval; // value returned to queries
	logic [7:0] ok_cnt;
	logic [7:0] err_cnt;
	logic pending; // a queued change waits for apply
	logic tx_busy;
	logic [3:0] tx_idx;
	logic [3:0] tx_last;
	logic [7:0] r_id;
	logic [15:0] r_name;
	logic r_query;
	logic [15:0] r_qval;
	logic fifo_valid;
	logic [7:0] fifo_data;
	logic take;
	logic frame_ok;
	logic csum_ok;
	logic good_end;
	logic apb_acc;
	logic apb_wr;
	logic sw_apply;

	// ===========================================
	// input buffer
	rpr_fifo #(
		.WIDTH(8),
		.DEPTH(`RPR_FIFO_DEPTH)
	) u_fifo (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.in_valid_i(rx_valid_i),
		.in_ready_o(rx_ready_o),
		.in_data_i(rx_data_i),
		.out_valid_o(fifo_valid),
		.out_ready_i(ctrl[`RPR_CTRL_EN] && !tx_busy),
		.out_data_o(fifo_data)
	);

	// parser stalls while a response drains, so the fifo backs up onto the host
	assign take = fifo_valid && ctrl[`RPR_CTRL_EN] && !tx_busy;
	assign csum_ok = (sum + fifo_data) == `RPR_CSUM_OK;
	// short, long or foreign frames never act
	assign frame_ok = (f_type == `RPR_TYPE_REQ) && (len >= `RPR_LEN_MIN) && !f_long;
	assign good_end = take && (state == rpr_pkg::RPR_ST_CSUM) && csum_ok && frame_ok;
	assign apb_acc = apb_i.psel && apb_i.penable && !pready_o;
	assign apb_wr = apb_acc && apb_i.pwrite;
	assign sw_apply = apb_wr && (apb_i.paddr == `RPR_REG_CTRL) && apb_i.pwdata[`RPR_CTRL_APPLY];

	// ===========================================
	// response byte at a given index, checksum folded in at the end
	function automatic logic [7:0] rsp_byte(input logic [3:0] idx, input logic [7:0] id,
			input logic [15:0] name, input logic q, input logic [15:0] qv);
		logic [7:0] b [11];
		logic [7:0] s;
		b[0] = `RPR_DELIM;
		b[1] = 8'h00;
		b[2] = q ? `RPR_RSP_LEN_QRY : `RPR_RSP_LEN_SET;
		b[3] = `RPR_TYPE_RSP;
		b[4] = id;
		b[5] = name[15:8];
		b[6] = name[7:0];
		b[7] = `RPR_STATUS_OK;
		b[8] = qv[15:8];
		b[9] = qv[7:0];
		b[10] = 8'h00;
		s = b[3] + b[4] + b[5] + b[6] + b[7] + (q ? (b[8] + b[9]) : 8'h00);
		rsp_byte = (idx == (q ? `RPR_RSP_LAST_QRY : `RPR_RSP_LAST_SET)) ? (`RPR_CSUM_OK - s) : b[idx];
	endfunction

	// ===========================================
	// frame parser state
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			state <= rpr_pkg::RPR_ST_IDLE;
			len <= 16'h0000;
			off <= 16'h0000;
			sum <= 8'h00;
		end else if (take) begin
			unique case (state)
				rpr_pkg::RPR_ST_IDLE: begin
					// anything but the delimiter is skipped while hunting
					if (fifo_data == `RPR_DELIM) begin
						state <= rpr_pkg::RPR_ST_LEN_HI;
					end
				end
				rpr_pkg::RPR_ST_LEN_HI: begin
					len[15:8] <= fifo_data;
					state <= rpr_pkg::RPR_ST_LEN_LO;
				end
				rpr_pkg::RPR_ST_LEN_LO: begin
					len[7:0] <= fifo_data;
					off <= `RPR_OFF_TYPE;
					sum <= 8'h00;
					// an empty body goes straight to the checksum
					state <= ({len[15:8], fifo_data} == 16'h0000) ? rpr_pkg::RPR_ST_CSUM : rpr_pkg::RPR_ST_BODY;
				end
				rpr_pkg::RPR_ST_BODY: begin
					sum <= sum + fifo_data;
					off <= off + 16'h0001;
					if (off == len + `RPR_LEN_TO_LAST) begin
						state <= rpr_pkg::RPR_ST_CSUM;
					end
				end
				rpr_pkg::RPR_ST_CSUM: begin
					state <= rpr_pkg::RPR_ST_IDLE;
				end
				default: begin
					state <= rpr_pkg::RPR_ST_IDLE;
				end
			endcase
		end
	end

	// ===========================================
	// field capture by offset
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			f_type <= 8'h00;
			f_id <= 8'h00;
			f_dest <= 64'h0000_0000_0000_0000;
			f_opts <= 8'h00;
			f_name <= 16'h0000;
			f_vlen <= 4'h0;
			f_long <= 1'b0;
		end else if (take && state == rpr_pkg::RPR_ST_LEN_LO) begin
			// fresh frame, forget the last one's type, value count and overrun flag
			f_type <= 8'h00;
			f_vlen <= 4'h0;
			f_long <= 1'b0;
		end else if (take && state == rpr_pkg::RPR_ST_BODY) begin
			if (off == `RPR_OFF_TYPE) begin
				f_type <= fifo_data;
			end
			if (off == `RPR_OFF_ID) begin
				f_id <= fifo_data;
			end
			if (off >= `RPR_OFF_ADDR && off <= `RPR_OFF_ADDR_END) begin
				f_dest <= {f_dest[55:0], fifo_data};
			end
			// the reserved pair at 13 is taken as it comes and not checked
			if (off == `RPR_OFF_OPTS) begin
				f_opts <= fifo_data;
			end
			if (off == `RPR_OFF_NAME_HI) begin
				f_name[15:8] <= fifo_data;
			end
			if (off == `RPR_OFF_NAME_LO) begin
				f_name[7:0] <= fifo_data;
			end
			if (off >= `RPR_OFF_VAL) begin
				// a value longer than the store is refused at the checksum
				if (f_vlen == `RPR_VAL_MAX) begin
					f_long <= 1'b1;
				end else begin
					f_vlen <= f_vlen + 4'h1;
				end
			end
		end
	end

	// ===========================================
	// value bytes in arrival order
	always_ff @(posedge sys_clk_i) begin
		if (take && state == rpr_pkg::RPR_ST_BODY && off >= `RPR_OFF_VAL && f_vlen != `RPR_VAL_MAX) begin
			val[f_vlen[2:0]] <= fifo_data;
		end
	end

	// ===========================================
	// accepted request to the radio side
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			req_valid_o <= 1'b0;
			req_o <= '0;
		end else begin
			req_valid_o <= good_end;
			if (good_end) begin
				req_o.dest <= f_dest;
				req_o.name <= f_name;
				req_o.id <= f_id;
				// each option bit steers its own flag, any mix allowed
				req_o.no_ack <= f_opts[`RPR_OPT_NOACK];
				req_o.apply_now <= f_opts[`RPR_OPT_APPLY];
				req_o.secure <= f_opts[`RPR_OPT_SECURE];
				req_o.is_query <= (f_vlen == 4'h0);
				req_o.val_len <= f_vlen;
			end
		end
	end

	// ===========================================
	// value copy held for software, array kept apart from the parse buffer
	always_ff @(posedge sys_clk_i) begin
		for (int i = 0; i < `RPR_VAL_MAX; i++) begin
			if (good_end) begin
				v_mem[i] <= val[i];
			end
		end
	end

	// ===========================================
	// queued change tracking and apply command
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			pending <= 1'b0;
			apply_cmd_o <= 1'b0;
		end else begin
			// a later apply-set request or software apply releases the queue
			apply_cmd_o <= sw_apply || (good_end && f_opts[`RPR_OPT_APPLY] && pending);
			if (good_end && f_vlen != 4'h0 && !f_opts[`RPR_OPT_APPLY]) begin
				pending <= 1'b1;
			end else if (sw_apply || (good_end && f_opts[`RPR_OPT_APPLY])) begin
				pending <= 1'b0;
			end
		end
	end

	// ===========================================
	// response sender
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			tx_busy <= 1'b0;
			tx_idx <= 4'h0;
			tx_last <= 4'h0;
			tx_valid_o <= 1'b0;
			tx_data_o <= 8'h00;
			r_id <= 8'h00;
			r_name <= 16'h0000;
			r_query <= 1'b0;
			r_qval <= 16'h0000;
		end else if (!tx_busy) begin
			tx_valid_o <= 1'b0;
			// zero frame id and bad frames get no answer
			if (good_end && f_id != 8'h00) begin
				tx_busy <= 1'b1;
				tx_idx <= 4'h1;
				r_id <= f_id;
				r_name <= f_name;
				r_query <= (f_vlen == 4'h0);
				r_qval <= qval;
				tx_last <= (f_vlen == 4'h0) ? `RPR_RSP_LAST_QRY : `RPR_RSP_LAST_SET;
				tx_valid_o <= 1'b1;
				tx_data_o <= `RPR_DELIM;
			end
		end else if (tx_ready_i) begin
			if (tx_idx == tx_last + 4'h1) begin
				tx_busy <= 1'b0;
				tx_valid_o <= 1'b0;
			end else begin
				tx_data_o <= rsp_byte(tx_idx, r_id, r_name, r_query, r_qval);
				tx_idx <= tx_idx + 4'h1;
			end
		end
	end

	// ===========================================
	// counters shown to software
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			ok_cnt <= 8'h00;
			err_cnt <= 8'h00;
		end else if (take && state == rpr_pkg::RPR_ST_CSUM) begin
			if (!csum_ok) begin
				err_cnt <= err_cnt + 8'h01;
			end else if (frame_ok) begin
				ok_cnt <= ok_cnt + 8'h01;
			end
		end
	end

	// ===========================================
	// apb writes
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			ctrl <= `RPR_CTRL_RESET;
			qval <= 16'h0000;
		end else if (apb_wr) begin
			// the apply bit is a pulse and is never stored
			if (apb_i.paddr == `RPR_REG_CTRL) begin
				ctrl <= {31'h0000_0000, apb_i.pwdata[`RPR_CTRL_EN]};
			end
			if (apb_i.paddr == `RPR_REG_QVAL) begin
				qval <= apb_i.pwdata[15:0];
			end
		end
	end

	// ===========================================
	// apb answer: one wait cycle, then pready with data
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o <= 32'h0000_0000;
		end else begin
			pready_o <= apb_acc;
			pslverr_o <= 1'b0;
			prdata_o <= 32'h0000_0000;
			if (apb_acc) begin
				unique case (apb_i.paddr)
					`RPR_REG_CTRL: prdata_o <= ctrl;
					`RPR_REG_STATUS: prdata_o <= {15'h0000, pending, err_cnt, ok_cnt};
					`RPR_REG_QVAL: prdata_o <= {16'h0000, qval};
					`RPR_REG_LAST: prdata_o <= {req_o.id, 3'h0, req_o.secure, 2'h0,
							req_o.apply_now, req_o.no_ack, req_o.name};
					`RPR_REG_DEST_HI: prdata_o <= req_o.dest[63:32];
					`RPR_REG_DEST_LO: prdata_o <= req_o.dest[31:0];
					`RPR_REG_VAL_HI: prdata_o <= {v_mem[0], v_mem[1], v_mem[2], v_mem[3]};
					`RPR_REG_VAL_LO: prdata_o <= {v_mem[4], v_mem[5], v_mem[6], v_mem[7]};
					`RPR_REG_VAL_LEN: prdata_o <= {27'h000_0000, req_o.is_query, req_o.val_len};
					default: pslverr_o <= 1'b1;
				endcase
			end
		end
	end
endmodule

// ==== tb/rpr_monitor.sv ====
// port-level checker of the remote parameter request framer
module rpr_monitor (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic tx_valid_o,
	input wire logic [7:0] tx_data_o,
	input wire logic tx_ready_i,
	input wire logic req_valid_o,
	input wire rpr_pkg::rpr_req_t req_o,
	input wire rpr_pkg::rpr_apb_req_t apb_i,
	input wire logic pready_o,
	input wire logic pslverr_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// ====
	// one clock domain, so one clocking for all
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (rst_i);
	// a numbered request opens its answer at once
	property p_delim;
		req_valid_o && req_o.id != 8'h00 |-> tx_valid_o && tx_data_o == 8'h7e;
	endproperty
	a_delim: assert property (p_delim) else $error("answer does not open with delimiter");
	// id zero keeps the answer path silent
	property p_quiet;
		req_valid_o && req_o.id == 8'h00 |-> !tx_valid_o;
	endproperty
	a_quiet: assert property (p_quiet) else $error("answer sent for id zero");
	// query exactly when no value bytes came
	property p_query;
		req_valid_o |-> req_o.is_query == (req_o.val_len == 4'h0);
	endproperty
	a_query: assert property (p_query) else $error("query flag wrong");
	property p_vmax;
		req_valid_o |-> req_o.val_len <= 4'h8;
	endproperty
	a_vmax: assert property (p_vmax) else $error("value too long");
	// a stalled byte must not change under the sink
	property p_hold;
		tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o);
	endproperty
	a_hold: assert property (p_hold) else $error("answer byte dropped");
	property p_ans;
		apb_i.psel && $rose(apb_i.penable) |=> pready_o;
	endproperty
	a_ans: assert property (p_ans) else $error("bus answer late");
	property p_once;
		pready_o |=> !pready_o;
	endproperty
	a_once: assert property (p_once) else $error("bus ready too long");
	property p_err;
		pslverr_o |-> pready_o;
	endproperty
	a_err: assert property (p_err) else $error("error without ready");
	property p_pulse;
		req_valid_o |=> !req_valid_o;
	endproperty
	a_pulse: assert property (p_pulse) else $error("request pulse too long");
endmodule

// ==== tb/rpr_host.sv ====
// host processor model: sends request frames, takes answer bytes
module rpr_host (
	input wire logic sys_clk_i,
	input wire logic rx_ready_i,
	output logic rx_valid_o,
	output logic [7:0] rx_data_o,
	input wire logic tx_valid_i,
	input wire logic [7:0] tx_data_i,
	output logic tx_ready_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic stall = 1'b0; // slow sink when set
	logic [7:0] rsp[$]; // answer bytes taken
	initial begin
		rx_valid_o = 1'b0;
		rx_data_o = 8'h00;
		tx_ready_o = 1'b1;
	end
	// sink takes every other cycle while stalling
	always @(posedge sys_clk_i) begin
		if (tx_valid_i && tx_ready_o)
			rsp.push_back(tx_data_i);
		tx_ready_o <= !stall || !tx_ready_o;
	end
	// whole frame around a body; bad spoils the checksum
	task automatic send(input logic [7:0] b[$], input logic bad);
		logic [7:0] f[$];
		logic [7:0] s;
		s = 8'h00;
		foreach (b[i]) s += b[i];
		f = {8'h7e, 8'h00, 8'(b.size()), b, (8'hff - s) ^ 8'(bad)};
		foreach (f[i]) begin
			rx_valid_o <= 1'b1;
			rx_data_o <= f[i];
			do @(posedge sys_clk_i); while (!rx_ready_i);
		end
		rx_valid_o <= 1'b0;
		// released line must not keep showing the last byte
		rx_data_o <= ~f[f.size()-1];
	endtask
endmodule

// ==== tb/rpr_framer_bench.sv ====
// self-checking bench of the remote parameter request framer
module rpr_framer_bench;
	timeunit 1ns;
	timeprecision 1ns;
	// ====
	// clock, wiring, counters
	// single unicast target, value arbitrary, never the broadcast address
	localparam logic [63:0] DEST = 64'h0102_0304_0506_0708;
	logic sys_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic rx_valid_i, rx_ready_o, tx_valid_o, tx_ready_i, req_valid_o, apply_cmd_o, pready_o, pslverr_o, se;
	logic [7:0] rx_data_i, tx_data_o;
	logic [31:0] prdata_o, rd;
	rpr_pkg::rpr_req_t req_o;
	rpr_pkg::rpr_apb_req_t apb_i = '0;
	int errors = 0, total_checks = 0, cyc = 0, napply = 0;
	logic [7:0] f[$], x[$];
	always #25 sys_clk_i = ~sys_clk_i;
	rpr_framer rpr_framer_inst (.sys_clk_i, .rst_i, .rx_valid_i, .rx_data_i, .rx_ready_o, .tx_valid_o,
		.tx_data_o, .tx_ready_i, .req_valid_o, .req_o, .apply_cmd_o, .apb_i, .prdata_o, .pready_o, .pslverr_o);
	rpr_host rpr_host_inst (.sys_clk_i, .rx_ready_i(rx_ready_o), .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i),
		.tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o), .tx_ready_o(tx_ready_i));
	// hang guard and apply pulse count
	always @(posedge sys_clk_i) begin
		cyc <= cyc + 1;
		napply <= napply + int'(apply_cmd_o);
		if (cyc == 5000) begin
			errors++;
			tally_and_finish();
		end
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			errors++;
			$display("unexpected %s: expected %h, seen %h", n, e, g);
		end
	endtask
	// apb: setup, access held until pready, then release
	// no local limit: only the hang guard ends a wait, and it counts as a mismatch
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		apb_i <= '{a, 1'b1, 1'b0, w, d};
		@(posedge sys_clk_i);
		apb_i.penable <= 1'b1;
		do @(posedge sys_clk_i); while (!pready_o);
		rd = prdata_o;
		se = pslverr_o;
		apb_i.psel <= 1'b0;
		apb_i.penable <= 1'b0;
		@(posedge sys_clk_i);
	endtask
	// request body from frame type on; x holds the value
	task automatic req(input logic [7:0] id, opt, input logic [15:0] nm, input logic bad);
		f = {8'h17, id};
		for (int i = 7; i >= 0; i--) f.push_back(DEST[i*8 +: 8]);
		f = {f, 8'hff, 8'hfe, opt, nm[15:8], nm[7:0], x};
		rpr_host_inst.rsp.delete();
		rpr_host_inst.send(f, bad);
		repeat (60) @(posedge sys_clk_i);
	endtask
	// answer expected: 7E 00 L 97 id name 00 [value] csum
	task automatic rsp(input logic [7:0] id, input logic [15:0] nm, qv, input logic q);
		logic [7:0] s;
		f = {8'h97, id, nm[15:8], nm[7:0], 8'h00};
		if (q)
			f = {f, qv[15:8], qv[7:0]};
		s = 8'hff;
		foreach (f[i]) s -= f[i];
		f = {8'h7e, 8'h00, 8'(f.size()), f, s};
		chk("rsp len", f.size(), rpr_host_inst.rsp.size());
		foreach (f[i]) chk("rsp byte", f[i], rpr_host_inst.rsp[i]);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d, errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// ====
	// main sequence
	initial begin
		repeat (10) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		@(posedge sys_clk_i);
		apb(1'b0, 8'h00, 32'h0000_0000);
		chk("ctrl", 32'h0000_0001, rd);
		apb(1'b0, 8'h24, 32'h0000_0000);
		chk("slverr", 1'b1, se);
		apb(1'b1, 8'h08, 32'h0000_fffe);
		// query: answer carries the query value
		x = {};
		req(8'hfa, 8'h00, 16'h5450, 1'b0);
		rsp(8'hfa, 16'h5450, 16'hfffe, 1'b1);
		chk("opts off", 3'b000, {req_o.no_ack, req_o.apply_now, req_o.secure});
		apb(1'b0, 8'h20, 32'h0000_0000);
		chk("query len", 32'h0000_0010, rd);
		apb(1'b0, 8'h08, 32'h0000_0000);
		chk("qval", 32'h0000_fffe, rd);
		// queued set, id zero, sent while parsing is stopped
		apb(1'b1, 8'h00, 32'h0000_0000);
		x = {8'h04, 8'h51};
		fork
			req(8'h00, 8'h00, 16'h4944, 1'b0);
		join_none
		repeat (30) @(posedge sys_clk_i);
		chk("rx ready", 1'b0, rx_ready_o);
		apb(1'b1, 8'h00, 32'h0000_0001);
		wait fork;
		chk("rsp count", 0, rpr_host_inst.rsp.size());
		chk("val len", 4'h2, req_o.val_len);
		apb(1'b0, 8'h04, 32'h0000_0000);
		chk("pending", 32'h0001_0002, rd);
		// all options, full value, slow sink
		rpr_host_inst.stall <= 1'b1;
		x = {8'h52, 8'h65, 8'h6d, 8'h6f, 8'h74, 8'h65, 8'h21, 8'h21};
		req(8'h27, 8'h13, 16'h4e49, 1'b0);
		rsp(8'h27, 16'h4e49, 16'h0000, 1'b0);
		chk("opts", 3'b111, {req_o.no_ack, req_o.apply_now, req_o.secure});
		chk("apply", 1, napply);
		apb(1'b0, 8'h0c, 32'h0000_0000);
		chk("last", 32'h2713_4e49, rd);
		apb(1'b0, 8'h10, 32'h0000_0000);
		chk("dest hi", DEST[63:32], rd);
		apb(1'b0, 8'h14, 32'h0000_0000);
		chk("dest lo", DEST[31:0], rd);
		apb(1'b0, 8'h18, 32'h0000_0000);
		chk("val hi", 32'h5265_6d6f, rd);
		apb(1'b0, 8'h1c, 32'h0000_0000);
		chk("val lo", 32'h7465_2121, rd);
		apb(1'b0, 8'h20, 32'h0000_0000);
		chk("val count", 32'h0000_0008, rd);
		// spoiled checksum
		x = {8'h01};
		req(8'h33, 8'h02, 16'h4e49, 1'b1);
		chk("bad rsp", 0, rpr_host_inst.rsp.size());
		// nine value bytes overrun the store: no request, no answer, no count
		x = {8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09};
		req(8'h34, 8'h00, 16'h4e49, 1'b0);
		chk("long rsp", 0, rpr_host_inst.rsp.size());
		apb(1'b0, 8'h04, 32'h0000_0000);
		chk("status", 32'h0000_0103, rd);
		// queue then apply by software
		x = {8'h07};
		req(8'h00, 8'h00, 16'h4944, 1'b0);
		apb(1'b1, 8'h00, 32'h0000_0003);
		chk("sw apply", 2, napply);
		apb(1'b0, 8'h04, 32'h0000_0000);
		chk("cleared", 32'h0000_0104, rd);
		tally_and_finish();
	end
endmodule
bind rpr_framer rpr_monitor rpr_monitor_inst (.sys_clk_i, .rst_i, .tx_valid_o, .tx_data_o, .tx_ready_i,
	.req_valid_o, .req_o, .apb_i, .pready_o, .pslverr_o);
